// >>> src/bie_pkg.sv
package bie_pkg;

  // ----------------------------------------------------------------------
  // Widths of the instruction path.
  // ----------------------------------------------------------------------
  localparam int WORD_W  = 14;
  localparam int PC_W    = 13;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;
  localparam int IMM_W   = 11;
  localparam int PAGE_W  = 8;

  // ----------------------------------------------------------------------
  // Field positions inside a program word.
  // ----------------------------------------------------------------------
  localparam int JUMP_OP_MSB   = 13;
  localparam int JUMP_OP_LSB   = 11;
  localparam int ALU_OP_MSB    = 13;
  localparam int ALU_OP_LSB    = 8;
  localparam int DIR_BIT       = 7;
  localparam int FADDR_MSB     = 6;
  localparam int IMM_MSB       = 10;
  localparam int PAGE_LATCH_HI = 4;
  localparam int PAGE_LATCH_LO = 3;

  // ----------------------------------------------------------------------
  // Opcode patterns.
  // ----------------------------------------------------------------------
  localparam logic [2:0] OP_JUMP_ABSOLUTE          = 3'h5;
  localparam logic [5:0] OP_INCREMENT_SKIP_IF_ZERO = 6'h0f;
  localparam logic [5:0] OP_INCREMENT_REGISTER     = 6'h0a;

  // The word loaded in place of a discarded instruction.
  localparam logic [WORD_W-1:0] IDLE_OPERATION_WORD = 14'h0000;

  // ----------------------------------------------------------------------
  // Reset values and steps.
  // ----------------------------------------------------------------------
  localparam logic [PC_W-1:0]    PC_RESET    = 13'h0000;
  localparam logic [PC_W-1:0]    PC_STEP     = 13'h0001;
  localparam logic [DATA_W-1:0]  ACCUM_RESET = 8'h00;
  localparam logic               ZERO_RESET  = 1'b0;
  localparam logic [FADDR_W-1:0] FADDR_RESET = 7'h00;

  // ----------------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------------
  typedef enum logic {CYCLE_EXECUTE, CYCLE_FLUSH} cycle_state_t;

  typedef struct packed {
    logic               jump;
    logic               incSkip;
    logic               incPlain;
    logic               toFile;
    logic [IMM_W-1:0]   target;
    logic [FADDR_W-1:0] fileAddr;
  } decoded_t;

  typedef struct packed {
    logic               en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } file_write_t;

endpackage : bie_pkg

// >>> src/increment_unit.sv
`timescale 1ns/1ps

module increment_unit #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] operand,
  output logic      [WIDTH-1:0] result,
  output logic                  isZero
);

  // ----------------------------------------------------------------------
  // Add one and report a zero result.
  // ----------------------------------------------------------------------

  // The sum is cut back to the operand width, so all ones wraps to zero.
  always_comb begin
    result = WIDTH'(operand + WIDTH'(1));
    isZero = (result == '0);
  end

endmodule : increment_unit

// >>> src/branch_and_increment_exec.sv
// How it works
// RULE1: A word whose top three bits are 101 is an absolute jump to its low eleven bits, no flag.
// RULE2: The jump puts its eleven-bit immediate into program counter bits 10 to 0.
// RULE3: The jump fills program counter bits 12 and 11 from page latch bits 4 and 3.
// RULE4: The jump is one word and spends two cycles, its own and one discarded fetch.
// RULE5: Pattern 00 1111 d fffffff is increment-skip, adding one and leaving all flags alone.
// RULE6: Pattern 00 1010 d fffffff is a plain increment, adding one and updating the zero flag.
// RULE7: With the direction bit at 0 the sum goes to the accumulator and the register stays.
// RULE8: With the direction bit at 1 the sum is written back into the addressed register.
// RULE9: A zero result of increment-skip discards the already fetched next instruction.
// RULE10: Increment-skip takes one cycle, or two with an idle operation when it skips.
// RULE11: Increments wrap modulo 256 and the plain increment sets zero only on a zero sum.
// RULE12: In the second jump cycle the sequential prefetch is dropped and the target is fetched.
`timescale 1ns/1ps

module branch_and_increment_exec (
  input  wire logic                         sys_clk,
  input  wire logic                         reset_n,
  input  wire logic [bie_pkg::WORD_W-1:0]   fetchWord,
  input  wire logic [bie_pkg::PAGE_W-1:0]   upperPageLatch,
  input  wire logic [bie_pkg::DATA_W-1:0]   fileReadData,
  output logic      [bie_pkg::PC_W-1:0]     fetchAddr,
  output logic      [bie_pkg::FADDR_W-1:0]  fileReadAddr,
  output bie_pkg::file_write_t              fileWrite,
  output logic      [bie_pkg::DATA_W-1:0]   accum,
  output logic                              zeroFlag,
  output logic                              zeroUpdate,
  output logic                              discarding
);

  // ----------------------------------------------------------------------
  // Internal state.
  // ----------------------------------------------------------------------
  logic [bie_pkg::WORD_W-1:0] instrReg;
  bie_pkg::cycle_state_t      cycleState;
  bie_pkg::cycle_state_t      next_cycleState;
  bie_pkg::decoded_t          decoded;
  logic [bie_pkg::PC_W-1:0]   jumpTarget;
  logic [bie_pkg::PC_W-1:0]   next_pc;
  logic [bie_pkg::DATA_W-1:0] operand;
  logic [bie_pkg::DATA_W-1:0] sum;
  logic                       sumIsZero;
  logic                       incAny;
  logic                       skipTaken;
  logic                       squash;

  // ----------------------------------------------------------------------
  // Decode.
  // ----------------------------------------------------------------------

  // Split the executing word into its opcode classes and operand fields.
  always_comb begin
    decoded.jump     = (instrReg[bie_pkg::JUMP_OP_MSB:bie_pkg::JUMP_OP_LSB]
                        == bie_pkg::OP_JUMP_ABSOLUTE);                              // [RULE1]
    decoded.incSkip  = (instrReg[bie_pkg::ALU_OP_MSB:bie_pkg::ALU_OP_LSB]
                        == bie_pkg::OP_INCREMENT_SKIP_IF_ZERO);                     // [RULE5]
    decoded.incPlain = (instrReg[bie_pkg::ALU_OP_MSB:bie_pkg::ALU_OP_LSB]
                        == bie_pkg::OP_INCREMENT_REGISTER);                         // [RULE6]
    decoded.toFile   = instrReg[bie_pkg::DIR_BIT];
    decoded.target   = instrReg[bie_pkg::IMM_MSB:0];
    decoded.fileAddr = instrReg[bie_pkg::FADDR_MSB:0];
  end

  // The jump target joins two page latch bits above the immediate.
  assign jumpTarget = {upperPageLatch[bie_pkg::PAGE_LATCH_HI:bie_pkg::PAGE_LATCH_LO],
                       decoded.target};                                              // [RULE2] [RULE3]

  // ----------------------------------------------------------------------
  // Operand forwarding and the incrementer.
  // ----------------------------------------------------------------------

  // A write still on its way to the register file is newer than its read data.
  always_comb begin
    if (fileWrite.en && (fileWrite.addr == decoded.fileAddr)) begin
      operand = fileWrite.data;
    end else begin
      operand = fileReadData;
    end
  end

  // One shared adder serves both increment instructions.
  increment_unit #(
    .WIDTH (bie_pkg::DATA_W)
  ) u_increment (
    .operand (operand),
    .result  (sum),
    .isZero  (sumIsZero)
  );                                                                                 // [RULE11]

  assign incAny    = decoded.incSkip || decoded.incPlain;
  assign skipTaken = decoded.incSkip && sumIsZero;                                   // [RULE9]

  // A jump or a taken skip throws away the word now being fetched.
  assign squash    = decoded.jump || skipTaken;                                      // [RULE4] [RULE10]

  // ----------------------------------------------------------------------
  // Cycle sequencing.
  // ----------------------------------------------------------------------

  // The flush state marks the idle cycle that follows a jump or a taken skip.
  always_comb begin
    next_cycleState = bie_pkg::CYCLE_EXECUTE;
    unique case (cycleState)
      bie_pkg::CYCLE_EXECUTE: begin
        if (squash) begin
          next_cycleState = bie_pkg::CYCLE_FLUSH;                                    // [RULE4] [RULE10]
        end
      end
      bie_pkg::CYCLE_FLUSH: begin
        next_cycleState = bie_pkg::CYCLE_EXECUTE;
      end
    endcase
  end

  // Hold the sequencing state.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cycleState <= bie_pkg::CYCLE_EXECUTE;
    end else begin
      cycleState <= next_cycleState;
    end
  end

  // Show the discarded cycle at a port.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      discarding <= 1'b0;
    end else begin
      discarding <= squash;                                                          // [RULE9]
    end
  end

  // ----------------------------------------------------------------------
  // Program counter and fetch.
  // ----------------------------------------------------------------------

  // A jump redirects the fetch, everything else steps sequentially.
  always_comb begin
    if (decoded.jump) begin
      next_pc = jumpTarget;                                                          // [RULE2] [RULE3]
    end else begin
      next_pc = bie_pkg::PC_W'(fetchAddr + bie_pkg::PC_STEP);
    end
  end

  // The program counter is the fetch address itself.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchAddr <= bie_pkg::PC_RESET;
    end else begin
      fetchAddr <= next_pc;                                                          // [RULE12]
    end
  end

  // Latch the fetched word, or an idle operation in place of a discarded one.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      instrReg <= bie_pkg::IDLE_OPERATION_WORD;
    end else if (squash) begin
      instrReg <= bie_pkg::IDLE_OPERATION_WORD;                                      // [RULE9] [RULE12]
    end else begin
      instrReg <= fetchWord;
    end
  end

  // Present the register address one cycle ahead so its data is ready at execute.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fileReadAddr <= bie_pkg::FADDR_RESET;
    end else if (squash) begin
      fileReadAddr <= bie_pkg::FADDR_RESET;
    end else begin
      fileReadAddr <= fetchWord[bie_pkg::FADDR_MSB:0];
    end
  end

  // ----------------------------------------------------------------------
  // Result destinations.
  // ----------------------------------------------------------------------

  // With the direction bit clear the sum lands in the accumulator.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      accum <= bie_pkg::ACCUM_RESET;
    end else if (incAny && !decoded.toFile) begin
      accum <= sum;                                                                  // [RULE7]
    end
  end

  // With the direction bit set the sum goes back to the addressed register.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fileWrite <= '0;
    end else begin
      fileWrite.en   <= incAny && decoded.toFile;                                    // [RULE7] [RULE8]
      fileWrite.addr <= decoded.fileAddr;
      fileWrite.data <= sum;                                                         // [RULE8]
    end
  end

  // ----------------------------------------------------------------------
  // Zero flag.
  // ----------------------------------------------------------------------

  // Only the plain increment touches the flag; jump and skip leave it alone.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      zeroFlag <= bie_pkg::ZERO_RESET;
    end else if (decoded.incPlain) begin
      zeroFlag <= sumIsZero;                                                         // [RULE6] [RULE11]
    end
  end

  // Pulse for one cycle whenever the flag has been rewritten.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      zeroUpdate <= 1'b0;
    end else begin
      zeroUpdate <= decoded.incPlain;                                                // [RULE1] [RULE5]
    end
  end

endmodule : branch_and_increment_exec

// >>> test/bie_exec_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the jump and increment block.
// ----------------------------------------
module bie_exec_chk (
  input wire logic                          sys_clk,
  input wire logic                          reset_n,
  input wire logic [bie_pkg::WORD_W-1:0]    fetchWord,
  input wire logic [bie_pkg::PAGE_W-1:0]    upperPageLatch,
  input wire logic [bie_pkg::DATA_W-1:0]    fileReadData,
  input wire logic [bie_pkg::PC_W-1:0]      fetchAddr,
  input wire bie_pkg::file_write_t          fileWrite,
  input wire logic [bie_pkg::DATA_W-1:0]    accum,
  input wire logic                          zeroFlag,
  input wire logic                          zeroUpdate,
  input wire logic                          discarding
);
  logic [13:0] word;
  logic [12:0] target;
  logic [7:0]  opnd, sum;
  logic [6:0]  fAddr;
  logic        isJump, isSkip, isInc, wrap;
  // Decode of the mirrored word; a pending write is forwarded to the operand.
  assign opnd   = (fileWrite.en && fileWrite.addr == fAddr) ? fileWrite.data : fileReadData;
  assign sum    = opnd + 8'h01;
  assign wrap   = opnd == 8'hff;
  assign fAddr  = word[6:0];
  assign target = {upperPageLatch[4:3], word[10:0]};
  assign isJump = word[13:11] == bie_pkg::OP_JUMP_ABSOLUTE;
  assign isSkip = word[13:8] == bie_pkg::OP_INCREMENT_SKIP_IF_ZERO;
  assign isInc  = word[13:8] == bie_pkg::OP_INCREMENT_REGISTER;
  // Mirror of the executing word; a dropped fetch becomes idle.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) word <= bie_pkg::IDLE_OPERATION_WORD;
    else if (isJump || (isSkip && wrap)) word <= bie_pkg::IDLE_OPERATION_WORD;
    else word <= fetchWord;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_jump_target; isJump |=> fetchAddr == $past(target); endproperty
  a_jump_target: assert property (p_jump_target) else $error("bad jump target");
  property p_jump_quiet;
    isJump |=> discarding && !fileWrite.en && !zeroUpdate && $stable(zeroFlag);
  endproperty
  a_jump_quiet: assert property (p_jump_quiet) else $error("jump side effect");
  property p_skip_taken;
    isSkip && wrap |=> discarding ##1 (!fileWrite.en && !zeroUpdate && !discarding);
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("skip not idle");
  property p_skip_kept; isSkip && !wrap |=> !discarding; endproperty
  a_skip_kept: assert property (p_skip_kept) else $error("false skip");
  property p_skip_flags; isSkip |=> !zeroUpdate && $stable(zeroFlag); endproperty
  a_skip_flags: assert property (p_skip_flags) else $error("skip moved zero");
  property p_inc_zero; isInc |=> zeroUpdate && zeroFlag == $past(wrap); endproperty
  a_inc_zero: assert property (p_inc_zero) else $error("bad zero flag");
  property p_to_file;
    (isInc || isSkip) && word[7] |=>
      fileWrite.en && fileWrite.addr == $past(fAddr) && fileWrite.data == $past(sum);
  endproperty
  a_to_file: assert property (p_to_file) else $error("bad file write");
  property p_to_accum;
    (isInc || isSkip) && !word[7] |=> !fileWrite.en && accum == $past(sum);
  endproperty
  a_to_accum: assert property (p_to_accum) else $error("bad accum");
  property p_other; !isJump && !isSkip && !isInc |=> !fileWrite.en && !zeroUpdate; endproperty
  a_other: assert property (p_other) else $error("idle word acted");
  c_jump: cover property (isJump);
  c_skip: cover property (isSkip && wrap);
  c_wrap: cover property (isInc && wrap);
endmodule : bie_exec_chk

bind branch_and_increment_exec bie_exec_chk u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .fetchWord(fetchWord),
  .upperPageLatch(upperPageLatch), .fileReadData(fileReadData), .fetchAddr(fetchAddr),
  .fileWrite(fileWrite), .accum(accum), .zeroFlag(zeroFlag), .zeroUpdate(zeroUpdate),
  .discarding(discarding)
);

// >>> test/branch_and_increment_exec_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench for the jump and increment block.
// ----------------------------------------
module branch_and_increment_exec_tb;
  localparam logic [5:0] INC = bie_pkg::OP_INCREMENT_REGISTER;
  localparam logic [5:0] ISZ = bie_pkg::OP_INCREMENT_SKIP_IF_ZERO;
  typedef struct packed {
    logic [13:0] word;
    logic [7:0]  operand;
    logic [7:0]  result;
    logic        skip;
  } row_t;
  logic                 sys_clk        = 1'b0;
  logic                 reset_n        = 1'b0;
  logic [7:0]           upperPageLatch = 8'h00;
  logic [13:0]          fetchWord, prog [0:8191];
  logic [7:0]           fileReadData, accum, regs [0:127];
  logic [12:0]          fetchAddr;
  logic [6:0]           fileReadAddr;
  bie_pkg::file_write_t fileWrite;
  logic                 zeroFlag, zeroUpdate, discarding, z0, inc;
  int                   failures = 0;
  int                   compares = 0;
  row_t rows [7] = '{'{{INC, 8'h10}, 8'h41, 8'h42, 1'b0}, '{{INC, 8'h7f}, 8'h00, 8'h01, 1'b0},
    '{{INC, 8'h91}, 8'hff, 8'h00, 1'b0}, '{{ISZ, 8'h92}, 8'h05, 8'h06, 1'b0},
    '{{ISZ, 8'h7f}, 8'hff, 8'h00, 1'b1}, '{{ISZ, 8'h80}, 8'hff, 8'h00, 1'b1},
    '{{ISZ, 8'h13}, 8'hfe, 8'hff, 1'b0}};
  // Program memory and register file read combinationally; writes land at the edge.
  assign fetchWord    = prog[fetchAddr];
  assign fileReadData = regs[fileReadAddr];
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (fileWrite.en) regs[fileWrite.addr] <= fileWrite.data;
  branch_and_increment_exec DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .fetchWord(fetchWord),
    .upperPageLatch(upperPageLatch), .fileReadData(fileReadData), .fetchAddr(fetchAddr),
    .fileReadAddr(fileReadAddr), .fileWrite(fileWrite), .accum(accum), .zeroFlag(zeroFlag),
    .zeroUpdate(zeroUpdate), .discarding(discarding)
  );
  // Compares a value and a flag, counting each.
  task automatic chkv(input logic [12:0] got, input logic [12:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chkv
  task automatic chkf(input logic got, input logic exp, input string m);
    chkv({12'h000, got}, {12'h000, exp}, m);
  endtask : chkf
  // Puts a word where the program counter points now.
  task automatic place(input logic [13:0] w);
    @(negedge sys_clk);
    prog[fetchAddr] = w;
  endtask : place
  task automatic end_of_test;
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // Watchdog well beyond the expected run.
  initial begin
    repeat (1000) @(posedge sys_clk);
    failures++;
    end_of_test();
  end
  // Main sequence: reset, table rows, then the awkward cases.
  initial begin
    foreach (prog[i]) prog[i] = '0;
    foreach (regs[i]) regs[i] = '0;
    repeat (10) @(posedge sys_clk);
    chkv(fetchAddr, 13'h0000, "reset pc");
    chkv(accum, 8'h00, "reset accum");
    chkf(zeroFlag | zeroUpdate | discarding | fileWrite.en, 1'b0, "reset flags");
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      z0 = zeroFlag;
      place(rows[i].word);
      regs[rows[i].word[6:0]] = rows[i].operand;
      repeat (2) @(negedge sys_clk);
      inc = rows[i].word[13:8] === INC;
      chkf(fileWrite.en, rows[i].word[7], "dest");
      if (rows[i].word[7]) chkv(fileWrite.data, rows[i].result, "file data");
      else chkv(accum, rows[i].result, "accum");
      chkf(zeroFlag, inc ? rows[i].result == 8'h00 : z0, "zero");
      chkf(zeroUpdate, inc, "zero update");
      chkf(discarding, rows[i].skip, "discard");
    end
    regs[7'h30] = 8'h10;
    place({INC, 8'hb0});
    place({INC, 8'hb0});
    repeat (3) @(negedge sys_clk);
    chkv(regs[7'h30], 8'h12, "back to back");
    regs[7'h31] = 8'hff;
    regs[7'h20] = 8'h55;
    place({ISZ, 8'hb1});
    place({INC, 8'ha0});
    repeat (3) @(negedge sys_clk);
    chkv(regs[7'h20], 8'h55, "skipped word ran");
    chkv(regs[7'h31], 8'h00, "skip wrap");
    @(posedge sys_clk) upperPageLatch <= 8'h6b;
    prog[13'h0aa5] = {INC, 8'h21};
    regs[7'h21] = 8'h07;
    z0 = zeroFlag;
    place({bie_pkg::OP_JUMP_ABSOLUTE, 11'h2a5});
    place({INC, 8'ha0});
    @(negedge sys_clk);
    chkv(fetchAddr, 13'h0aa5, "jump target");
    chkf(discarding, 1'b1, "jump discard");
    chkv(fileReadAddr, 13'h0000, "dropped read addr");
    chkf(zeroFlag, z0, "jump zero");
    repeat (2) @(negedge sys_clk);
    chkv(accum, 8'h08, "target word");
    chkv(regs[7'h20], 8'h55, "dropped word ran");
    @(posedge sys_clk) reset_n <= 1'b0;
    @(negedge sys_clk);
    chkv(fetchAddr, 13'h0000, "mid reset pc");
    chkv(accum, 8'h00, "mid reset accum");
    end_of_test();
  end
endmodule : branch_and_increment_exec_tb
